// ===== rtl/plsl_top.sv
// Serial side of a bit-oriented packet link controller with its register port.
// Assumes transmit and receive clocks come from the modem, slow against the core clock.
//
// Notes on behaviour
// - Receive, transmit and register port run independently.
// - New transmit bit on transmit clock fall.
// - Receive bit sampled on receive clock rise.
// - Idle ones until first frame sent.
// - Flags between frames after first frame or initiate.
// - Sixteen software registers configure the controller.
// - Memory tables hold eight packets, chaining, flags.
// - Single pointer locates transmit table segment zero.
// - Receive table sits hex 40 past transmit.
// - Event sets status 1 bit and interrupt flag.
// - Events: packet received, acknowledged, fatal error.
// - Loop-back feeds transmit data into receiver.
// - Loop-back drives receive clock from transmit clock.
// - Full segment carries two transfer address bytes.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
module plsl_top
    import plsl_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic arst_n,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Transmit byte source and link events from the frame engine.
    input wire logic tx_valid,
    input wire plsl_byte_t tx_byte,
    output logic tx_ready,
    input wire logic tx_ack_in,
    // Received bytes toward memory.
    output logic rx_valid,
    output plsl_byte_t rx_byte,
    // Memory table layout.
    output plsl_layout_t layout,
    // Modem pins.
    input wire logic transmit_clock_in,
    input wire logic receive_clock_in,
    input wire logic serial_rx_in,
    input wire logic clear_to_send_in,
    output logic serial_tx_out,
    output logic modem_request_out,
    output logic loopback_select,
    output logic irq_flag
);
    logic [7:0] regs_r [PLSL_NREGS];
    logic [3:0] stat_r;
    logic [3:0] stat_set;
    logic [7:0] rdata_r;
    logic tc_s1, tc_s2, tc_s3;
    logic rc_s1, rc_s2;
    logic rd_s1, rd_s2;
    logic cts_s1, cts_s2;
    logic rclk_prev_r;
    logic rclk_src, rbit_src;
    logic tx_fall, rx_rise;
    logic loop_on, init_on;
    plsl_tx_st_t tx_st_r;
    logic [7:0] tx_sh_r;
    logic [2:0] tx_cnt_r;
    logic [2:0] tx_ones_r;
    logic tx_last_r;
    logic tx_out_r;
    logic tx_rdy_r;
    logic flags_on_r;
    logic tx_done_ev, tx_err_ev;
    logic [2:0] rx_ones_r;
    logic [7:0] rx_sh_r;
    logic [2:0] rx_cnt_r;
    logic in_frame_r;
    logic [7:0] rx_hold_r;
    logic rx_have_r;
    logic rx_valid_r;
    plsl_byte_t rx_out_r;
    logic rx_pkt_ev, rx_err_ev;
    plsl_layout_t layout_r;
    logic rts_r, loop_r, irq_r;

    assign loop_on = regs_r[PLSL_CTRL][PLSL_C_LOOP];
    assign init_on = regs_r[PLSL_CTRL][PLSL_C_INIT];

    // Pin synchronisers; only the second stage and later are looked at.
    // Transmit clock stages reset low so that a low pin gives no false fall after reset.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tc_s1 <= 1'b0;
            tc_s2 <= 1'b0;
            tc_s3 <= 1'b0;
            rc_s1 <= 1'b0;
            rc_s2 <= 1'b0;
            rd_s1 <= 1'b1;
            rd_s2 <= 1'b1;
            cts_s1 <= 1'b0;
            cts_s2 <= 1'b0;
        end else begin
            tc_s1 <= transmit_clock_in;
            tc_s2 <= tc_s1;
            tc_s3 <= tc_s2;
            rc_s1 <= receive_clock_in;
            rc_s2 <= rc_s1;
            rd_s1 <= serial_rx_in;
            rd_s2 <= rd_s1;
            cts_s1 <= clear_to_send_in;
            cts_s2 <= cts_s1;
        end
    end

    // In loop-back the receiver hears the transmit clock and our own data, never the receive pins.
    assign rclk_src = loop_on ? tc_s2 : rc_s2;
    assign rbit_src = loop_on ? tx_out_r : rd_s2;
    assign tx_fall = tc_s3 & ~tc_s2;
    assign rx_rise = rclk_src & ~rclk_prev_r;

    // Receive clock edge history, kept apart from the source mux above.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rclk_prev_r <= 1'b0;
        end else begin
            rclk_prev_r <= rclk_src;
        end
    end

    // Register writes; status 1 is write-one-to-clear and a new event beats the clear.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < PLSL_NREGS; i++) begin
                regs_r[i] <= PLSL_REG_RST;
            end
            stat_r <= PLSL_STAT_RST;
        end else begin
            if (reg_wr && reg_addr != PLSL_STAT1) begin
                regs_r[reg_addr] <= reg_wdata;
            end
            if (reg_wr && reg_addr == PLSL_STAT1) begin
                stat_r <= (stat_r & ~reg_wdata[3:0]) | stat_set;
            end else begin
                stat_r <= stat_r | stat_set;
            end
        end
    end

    // Event collection into status 1.
    always_comb begin
        stat_set = 4'h0;
        stat_set[PLSL_S_RXPKT] = rx_pkt_ev;
        stat_set[PLSL_S_TXACK] = tx_ack_in;
        stat_set[PLSL_S_ERR] = rx_err_ev | tx_err_ev;
        stat_set[PLSL_S_TXDONE] = tx_done_ev;
    end

    // Read data stands one cycle after the read strobe; status reads back live bits.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= PLSL_REG_RST;
        end else if (reg_rd) begin
            if (reg_addr == PLSL_STAT1) begin
                rdata_r <= {4'h0, stat_r};
            end else begin
                rdata_r <= regs_r[reg_addr];
            end
        end
    end

    // Table layout from the single pointer and the chain settings.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            layout_r <= '0;
        end else begin
            layout_r.tx_table <= {regs_r[PLSL_PTR_HI], regs_r[PLSL_PTR_LO]};
            layout_r.rx_table <= {regs_r[PLSL_PTR_HI], regs_r[PLSL_PTR_LO]}
                + PLSL_RX_TABLE_OFS;
            layout_r.seg_stride <= 16'((({8'h00, regs_r[PLSL_LIMIT]} + 16'h0001)
                * PLSL_SEG_UNIT) + PLSL_XFR_BYTES);
            layout_r.seg_count <= {1'b0, regs_r[PLSL_CHAIN]} + 9'h001;
        end
    end

    // Transmit sequencer; it only moves on transmit clock falls, so the host port
    // never stalls it.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tx_st_r <= TX_GAP;
            tx_sh_r <= PLSL_IDLE;
            tx_cnt_r <= 3'h0;
            tx_ones_r <= 3'h0;
            tx_last_r <= 1'b0;
            tx_out_r <= 1'b1;
            tx_rdy_r <= 1'b0;
            flags_on_r <= 1'b0;
            tx_done_ev <= 1'b0;
            tx_err_ev <= 1'b0;
        end else begin
            tx_rdy_r <= 1'b0;
            tx_done_ev <= 1'b0;
            tx_err_ev <= 1'b0;
            if (init_on) begin
                flags_on_r <= 1'b1;
            end
            if (tx_fall) begin
                if ((tx_st_r == TX_DATA || tx_st_r == TX_CLOSE)
                    && tx_ones_r == PLSL_STUFF_ONES) begin
                    // Zero inserted after five data ones, even when the last byte ends
                    // the run, so the closing flag is never taken for a stuffed zero.
                    tx_out_r <= 1'b0;
                    tx_ones_r <= 3'h0;
                end else begin
                    tx_out_r <= tx_sh_r[0];
                    tx_sh_r <= {1'b1, tx_sh_r[7:1]};
                    tx_cnt_r <= tx_cnt_r + 3'h1;
                    if (tx_st_r == TX_DATA && tx_sh_r[0]) begin
                        tx_ones_r <= tx_ones_r + 3'h1;
                    end else begin
                        tx_ones_r <= 3'h0;
                    end
                    if (tx_cnt_r == 3'h7) begin
                        case (tx_st_r)
                            TX_GAP: begin
                                if (tx_valid && cts_s2) begin
                                    tx_sh_r <= PLSL_FLAG;
                                    tx_st_r <= TX_OPEN;
                                end else if (flags_on_r) begin
                                    tx_sh_r <= PLSL_FLAG;
                                end else begin
                                    tx_sh_r <= PLSL_IDLE;
                                end
                            end
                            TX_OPEN, TX_DATA: begin
                                if (tx_st_r == TX_DATA && tx_last_r) begin
                                    tx_sh_r <= PLSL_FLAG;
                                    tx_st_r <= TX_CLOSE;
                                end else if (tx_valid) begin
                                    tx_sh_r <= tx_byte.data;
                                    tx_last_r <= tx_byte.last;
                                    tx_rdy_r <= 1'b1;
                                    tx_st_r <= TX_DATA;
                                end else begin
                                    // Underrun: the frame is closed and reported as an error.
                                    tx_sh_r <= PLSL_FLAG;
                                    tx_st_r <= TX_CLOSE;
                                    tx_err_ev <= 1'b1;
                                end
                            end
                            TX_CLOSE: begin
                                tx_sh_r <= PLSL_FLAG;
                                tx_st_r <= TX_GAP;
                                tx_last_r <= 1'b0;
                                flags_on_r <= 1'b1;
                                tx_done_ev <= 1'b1;
                            end
                            default: begin
                                tx_st_r <= TX_GAP;
                            end
                        endcase
                    end
                end
            end
        end
    end

    // Receive deframer: flag hunt, zero deletion, one byte held back so that the
    // flag's own leading bits are never delivered as data.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rx_ones_r <= 3'h0;
            rx_sh_r <= 8'h00;
            rx_cnt_r <= 3'h0;
            in_frame_r <= 1'b0;
            rx_hold_r <= 8'h00;
            rx_have_r <= 1'b0;
            rx_valid_r <= 1'b0;
            rx_out_r <= '0;
            rx_pkt_ev <= 1'b0;
            rx_err_ev <= 1'b0;
        end else begin
            rx_valid_r <= 1'b0;
            rx_pkt_ev <= 1'b0;
            rx_err_ev <= 1'b0;
            if (rx_rise) begin
                if (rbit_src) begin
                    if (rx_ones_r != PLSL_ABORT_ONES) begin
                        rx_ones_r <= rx_ones_r + 3'h1;
                    end
                    if (rx_ones_r == PLSL_FLAG_ONES) begin
                        // Seven ones: abort or idle line ends any frame in progress.
                        if (in_frame_r && rx_have_r) begin
                            rx_err_ev <= 1'b1;
                        end
                        in_frame_r <= 1'b0;
                        rx_have_r <= 1'b0;
                    end
                end else begin
                    rx_ones_r <= 3'h0;
                end
                if (!rbit_src && rx_ones_r == PLSL_FLAG_ONES) begin
                    // Closing flag delivers a frame only when it falls on a byte edge.
                    if (in_frame_r && rx_have_r && rx_cnt_r == PLSL_FLAG_TAIL) begin
                        rx_out_r <= '{data: rx_hold_r, last: 1'b1};
                        rx_valid_r <= 1'b1;
                        rx_pkt_ev <= 1'b1;
                    end
                    in_frame_r <= 1'b1;
                    rx_have_r <= 1'b0;
                    rx_cnt_r <= 3'h0;
                end else if (!(!rbit_src && rx_ones_r == PLSL_STUFF_ONES) && in_frame_r) begin
                    rx_sh_r <= {rbit_src, rx_sh_r[7:1]};
                    rx_cnt_r <= rx_cnt_r + 3'h1;
                    if (rx_cnt_r == 3'h7) begin
                        if (rx_have_r) begin
                            rx_out_r <= '{data: rx_hold_r, last: 1'b0};
                            rx_valid_r <= 1'b1;
                        end
                        rx_hold_r <= {rbit_src, rx_sh_r[7:1]};
                        rx_have_r <= 1'b1;
                    end
                end
            end
        end
    end

    // Pin-facing outputs from flops; loop-back select lets outside logic hold the
    // modem request off and tie it to clear-to-send.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rts_r <= 1'b0;
            loop_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            rts_r <= regs_r[PLSL_CTRL][PLSL_C_RTS];
            loop_r <= loop_on;
            irq_r <= |stat_r;
        end
    end

    assign reg_rdata = rdata_r;
    assign tx_ready = tx_rdy_r;
    assign rx_valid = rx_valid_r;
    assign rx_byte = rx_out_r;
    assign layout = layout_r;
    assign serial_tx_out = tx_out_r;
    assign modem_request_out = rts_r;
    assign loopback_select = loop_r;
    assign irq_flag = irq_r;
endmodule // plsl_top

// ===== rtl/plsl_pkg.sv
// Package for the packet link serial block: register map, reset values, patterns.
// Assumes one 125 MHz clock domain; link clocks are sampled as plain inputs.
package plsl_pkg;
    // Register indices on the 4-bit register port.
    localparam logic [3:0] PLSL_CTRL = 4'h0;
    localparam logic [3:0] PLSL_STAT1 = 4'h1;
    localparam logic [3:0] PLSL_PTR_LO = 4'h2;
    localparam logic [3:0] PLSL_PTR_HI = 4'h3;
    localparam logic [3:0] PLSL_CHAIN = 4'h4;
    localparam logic [3:0] PLSL_LIMIT = 4'h5;
    localparam logic [3:0] PLSL_XCMD = 4'hE;
    localparam logic [3:0] PLSL_XRSP = 4'hF;
    // Control bit positions.
    localparam int PLSL_C_INIT = 0;
    localparam int PLSL_C_LOOP = 1;
    localparam int PLSL_C_RTS = 2;
    // Status register 1 bit positions.
    localparam int PLSL_S_RXPKT = 0;
    localparam int PLSL_S_TXACK = 1;
    localparam int PLSL_S_ERR = 2;
    localparam int PLSL_S_TXDONE = 3;
    localparam int PLSL_NREGS = 16;
    // Reset values.
    localparam logic [7:0] PLSL_REG_RST = 8'h00;
    localparam logic [3:0] PLSL_STAT_RST = 4'h0;
    // Line patterns.
    localparam logic [7:0] PLSL_FLAG = 8'h7E;
    localparam logic [7:0] PLSL_IDLE = 8'hFF;
    localparam logic [2:0] PLSL_STUFF_ONES = 3'h5;
    localparam logic [2:0] PLSL_FLAG_ONES = 3'h6;
    localparam logic [2:0] PLSL_ABORT_ONES = 3'h7;
    localparam logic [2:0] PLSL_FLAG_TAIL = 3'h7;
    // Memory table layout.
    localparam logic [15:0] PLSL_RX_TABLE_OFS = 16'h0040;
    localparam logic [15:0] PLSL_SEG_UNIT = 16'h0040;
    localparam logic [15:0] PLSL_XFR_BYTES = 16'h0002;
    localparam int PLSL_MAX_PKTS = 8;
    // Byte carriers.
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } plsl_byte_t;
    typedef struct packed {
        logic [15:0] tx_table;
        logic [15:0] rx_table;
        logic [15:0] seg_stride;
        logic [8:0] seg_count;
    } plsl_layout_t;
    typedef enum logic [1:0] {TX_GAP, TX_OPEN, TX_DATA, TX_CLOSE} plsl_tx_st_t;
endpackage

// ===== verif/plsl_monitor.sv
// Checker for the packet link serial block, watching top-level ports only.
// Assumes one core clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
module plsl_monitor
    import plsl_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic arst_n,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Byte and event side.
    input wire logic tx_ack_in,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire plsl_layout_t layout,
    // Modem pins.
    input wire logic transmit_clock_in,
    input wire logic serial_tx_out,
    input wire logic modem_request_out,
    input wire logic loopback_select,
    input wire logic irq_flag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // A register write to one index; the table checks look two cycles on.
    sequence s_wr(logic [3:0] a);
        reg_wr && reg_addr == a;
    endsequence

    // Line bits may only move while the transmit clock has been low for a while.
    property p_tx_edge;
        $changed(serial_tx_out) |-> !transmit_clock_in && !$past(transmit_clock_in, 2);
    endproperty
    a_tx_edge: assert property (p_tx_edge) else $error("line bit moved off a clock fall");
    property p_tx_gap; tx_ready |=> !tx_ready [*8]; endproperty
    a_tx_gap: assert property (p_tx_gap) else $error("transmit bytes taken too close");
    property p_rx_gap; rx_valid |=> !rx_valid [*8]; endproperty
    a_rx_gap: assert property (p_rx_gap) else $error("received bytes too close");
    property p_irq; tx_ack_in |-> ##2 irq_flag; endproperty
    a_irq: assert property (p_irq) else $error("acknowledge did not raise interrupt");
    property p_stat_hi; reg_rd && reg_addr == PLSL_STAT1 |=> reg_rdata[7:4] == 4'h0; endproperty
    a_stat_hi: assert property (p_stat_hi) else $error("status upper bits not zero");
    property p_loop;
        s_wr(PLSL_CTRL) |-> ##2 loopback_select == $past(reg_wdata[PLSL_C_LOOP], 2);
    endproperty
    a_loop: assert property (p_loop) else $error("loop-back select not following control");
    property p_rts;
        s_wr(PLSL_CTRL) |-> ##2 modem_request_out == $past(reg_wdata[PLSL_C_RTS], 2);
    endproperty
    a_rts: assert property (p_rts) else $error("request line not following control");
    property p_rx_tbl;
        s_wr(PLSL_PTR_LO) |-> ##2 layout.rx_table == layout.tx_table + 16'h0040;
    endproperty
    a_rx_tbl: assert property (p_rx_tbl) else $error("receive table offset wrong");
    property p_stride;
        s_wr(PLSL_LIMIT) |-> ##2
            layout.seg_stride == ({8'h00, $past(reg_wdata, 2)} + 16'h0001) * 16'h0040 + 16'h0002;
    endproperty
    a_stride: assert property (p_stride) else $error("segment stride wrong");
    property p_count;
        s_wr(PLSL_CHAIN) |-> ##2 layout.seg_count == {1'b0, $past(reg_wdata, 2)} + 9'h001;
    endproperty
    a_count: assert property (p_count) else $error("segment count wrong");
endmodule // plsl_monitor

// ===== verif/plsl_modem.sv
// Remote station and modem model: link clocks, the receive clock freezable, and framed receive data.
// Assumes the bench queues bytes through put and flag.
`timescale 1ns/1ps
module plsl_modem
    import plsl_pkg::*;
(
    // Link clocks.
    output logic tx_clk,
    output logic rx_clk,
    // Data and handshake lines.
    output logic rx_data,
    output logic cts,
    input wire logic rts,
    // Bench command: freeze the receive clock and scramble the data line.
    input wire logic rx_quiet
);
    logic bits [$];
    int ones = 0;
    // Request wired back to clear-to-send, as the loop-back wiring wants.
    assign cts = rts;
    // Both clocks run at 125 ns with unrelated phases; the receive clock holds while rx_quiet is high.
    initial begin
        tx_clk = 1'b0;
        #3.3;
        forever #62.5 tx_clk = ~tx_clk;
    end
    initial begin
        rx_clk = 1'b0;
        #21.7;
        forever begin
            #62.5;
            if (!rx_quiet) rx_clk = ~rx_clk;
        end
    end
    // Data moves on the fall so it is settled at the sampling rise; an idle line is ones.
    initial rx_data = 1'b1;
    always @(negedge rx_clk) rx_data <= (bits.size() > 0) ? bits.pop_front() : 1'b1;
    // A quiet line must never look like steady data, so it keeps toggling.
    always #40 if (rx_quiet) rx_data = ~rx_data;
    // Queue one byte LSB first, inserting a zero after five ones inside frames.
    task automatic put(input logic [7:0] d, input bit stuff);
        for (int i = 0; i < 8; i++) begin
            bits.push_back(d[i]);
            ones = (d[i] && stuff) ? ones + 1 : 0;
            if (ones == 5) begin
                bits.push_back(1'b0);
                ones = 0;
            end
        end
    endtask
    // Delimiter: zero, six ones, zero.
    task automatic flag();
        put(8'h7E, 1'b0);
    endtask
endmodule // plsl_modem

// ===== verif/plsl_top_tb.sv
// Bench for the packet link serial block: registers, line states, receive and loop-back.
// Assumes the package, monitor and modem model are compiled before this file.
`timescale 1ns/1ps
`define CHK(g, e) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        failures++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end
module plsl_top_tb
    import plsl_pkg::*;
;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic tx_valid = 1'b0;
    plsl_byte_t tx_byte = '0;
    logic tx_ready, tx_ack_in = 1'b0, rx_valid;
    plsl_byte_t rx_byte, e;
    plsl_layout_t layout;
    logic transmit_clock_in, receive_clock_in, serial_rx_in, clear_to_send_in;
    logic serial_tx_out, modem_request_out, loopback_select, irq_flag;
    logic rx_quiet = 1'b0;
    logic rd_d = 1'b0;
    logic [31:0] seed = 32'h000001F3;
    logic [7:0] sh = 8'h00;
    logic [7:0] v [16];
    logic [15:0] m;
    plsl_byte_t rxq [$];
    logic [15:0] rdq [$];
    int failures = 0;
    int total_checks = 0;

    // Core clock, 8 ns period.
    initial forever #4 clock = ~clock;

    plsl_top u_plsl_top (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .tx_valid, .tx_byte, .tx_ready, .tx_ack_in, .rx_valid, .rx_byte, .layout,
        .transmit_clock_in, .receive_clock_in, .serial_rx_in, .clear_to_send_in,
        .serial_tx_out, .modem_request_out, .loopback_select, .irq_flag);
    plsl_modem u_plsl_modem (.tx_clk(transmit_clock_in), .rx_clk(receive_clock_in),
        .rx_data(serial_rx_in), .cts(clear_to_send_in), .rts(modem_request_out),
        .rx_quiet(rx_quiet));

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Register cycles; a gap cycle between strobes keeps each strobe a single pulse.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] x);
        rdq.push_back({mask, x});
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
    endtask
    // Collect line bits at the transmit clock rise, LSB first.
    task automatic grab(input int n);
        repeat (n) begin
            @(posedge transmit_clock_in);
            sh = {serial_tx_out, sh[7:1]};
        end
    endtask
    // Offer n random bytes; cut leaves the frame open so the source runs dry.
    task automatic tx_frame(input int n, input bit loop, input bit cut);
        plsl_byte_t b;
        int k;
        for (int i = 0; i < n; i++) begin
            b.data = rnd();
            b.last = (i == n - 1) && !cut;
            if (loop) rxq.push_back(b);
            tx_byte <= b;
            tx_valid <= 1'b1;
            k = 0;
            do begin
                @(posedge clock);
                k++;
            end while (tx_ready !== 1'b1 && k < 4000);
            if (k >= 4000) failures++;
        end
        tx_valid <= 1'b0;
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task print_verdict();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Results side: read data in the cycle after the strobe, received bytes as they pulse.
    always @(posedge clock) begin
        rd_d <= reg_rd;
        if (rd_d) begin
            m = rdq.pop_front();
            `CHK(reg_rdata & m[15:8], m[7:0])
        end
        if (rx_valid) begin
            e = (rxq.size() > 0) ? rxq.pop_front() : ~rx_byte;
            `CHK(rx_byte, e)
        end
    end

    // A hang is cut off well beyond the expected run of about 35 us.
    initial begin
        #250us;
        failures++;
        print_verdict();
    end

    initial begin
        wt(2);
        arst_n <= 1'b1;
        rd(PLSL_CTRL, 8'hFF, 8'h00);
        rd(PLSL_STAT1, 8'hFF, 8'h00);
        repeat (2) begin
            grab(8);
            `CHK(sh, 8'hFF)
        end
        done("idle");
        @(posedge clock);
        tx_ack_in <= 1'b1;
        @(posedge clock);
        tx_ack_in <= 1'b0;
        rd(PLSL_STAT1, 8'hFF, 8'h02);
        wt(2);
        `CHK(irq_flag, 1'b1)
        wr(PLSL_STAT1, 8'h0F);
        wt(3);
        `CHK(irq_flag, 1'b0)
        done("events");
        for (int a = 2; a < 16; a++) begin
            v[a] = rnd();
            wr(4'(a), v[a]);
        end
        for (int a = 2; a < 16; a++) rd(4'(a), 8'hFF, v[a]);
        wt(2);
        `CHK(layout.tx_table, {v[3], v[2]})
        `CHK(layout.rx_table, {v[3], v[2]} + 16'h0040)
        `CHK(layout.seg_count, {1'b0, v[4]} + 9'h001)
        `CHK(layout.seg_stride, ({8'h00, v[5]} + 16'h0001) * 16'h0040 + 16'h0002)
        done("registers");
        wr(PLSL_CTRL, 8'h05);
        grab(8);
        for (int i = 0; i < 64 && sh !== 8'h7E; i++) grab(1);
        grab(8);
        `CHK(sh, 8'h7E)
        done("flags");
        wr(PLSL_STAT1, 8'h0F);
        tx_frame(1, 1'b0, 1'b1);
        wt(600);
        rd(PLSL_STAT1, 8'h04, 8'h04);
        done("underrun");
        wr(PLSL_STAT1, 8'h0F);
        v[0] = rnd();
        v[1] = 8'hFF;
        rxq.push_back({v[0], 1'b0});
        rxq.push_back({v[1], 1'b1});
        u_plsl_modem.flag();
        u_plsl_modem.put(v[0], 1'b1);
        u_plsl_modem.put(v[1], 1'b1);
        u_plsl_modem.flag();
        wt(900);
        `CHK(rxq.size(), 0)
        rd(PLSL_STAT1, 8'h01, 8'h01);
        u_plsl_modem.flag();
        u_plsl_modem.put(8'h00, 1'b1);
        u_plsl_modem.put(8'hFF, 1'b0);
        wt(600);
        rd(PLSL_STAT1, 8'h04, 8'h04);
        done("receive");
        rx_quiet <= 1'b1;
        wr(PLSL_XCMD, 8'h5A);
        wr(PLSL_XRSP, 8'h5A);
        wr(PLSL_CTRL, 8'h07);
        wt(3);
        `CHK(loopback_select, 1'b1)
        wr(PLSL_STAT1, 8'h0F);
        tx_frame(3, 1'b1, 1'b0);
        wt(600);
        `CHK(rxq.size(), 0)
        rd(PLSL_STAT1, 8'h09, 8'h09);
        wt(3);
        `CHK(irq_flag, 1'b1)
        done("loopback");
        print_verdict();
    end
endmodule // plsl_top_tb

bind plsl_top plsl_monitor u_plsl_monitor (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .tx_ack_in, .tx_ready, .rx_valid, .layout, .transmit_clock_in,
    .serial_tx_out, .modem_request_out, .loopback_select, .irq_flag);
